// ===== hdl/pcg_clock_gen_defines.vh
// register map, field positions and reset values of the pll clock generator control
`ifndef PCG_CLOCK_GEN_DEFINES_VH
`define PCG_CLOCK_GEN_DEFINES_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define PCG_OFS_CONTROL      4'h0
`define PCG_OFS_BANDWIDTH    4'h4
`define PCG_OFS_PROGRAMMING  4'h8
`define PCG_OFS_BREAK_FLAG   4'hC

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define PCG_CTL_IRQ_EN_BIT   7
`define PCG_CTL_FLAG_BIT     6
`define PCG_CTL_PWR_ON_BIT   5
`define PCG_CTL_BCS_BIT      4
`define PCG_CTL_UNUSED_VAL   4'hF

// ----------------------------------------------------------------------------
// bandwidth control register fields
// ----------------------------------------------------------------------------
`define PCG_BW_AUTO_BIT      7
`define PCG_BW_LOCK_BIT      6
`define PCG_BW_TRACK_BIT     5
`define PCG_BW_XLD_BIT       4

// ----------------------------------------------------------------------------
// programming register fields
// ----------------------------------------------------------------------------
`define PCG_PRG_MUL_MSB      7
`define PCG_PRG_MUL_LSB      4
`define PCG_PRG_VRS_MSB      3
`define PCG_PRG_VRS_LSB      0

// ----------------------------------------------------------------------------
// break flag control register fields
// ----------------------------------------------------------------------------
`define PCG_BRK_BREAK_CLEAR_ENABLE_BIT     7

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PCG_MUL_RESET        4'h6
`define PCG_VRS_RESET        4'h6
`define PCG_PWR_ON_RESET     1'b1

// ----------------------------------------------------------------------------
// base clock switch
// ----------------------------------------------------------------------------
`define PCG_SWITCH_EDGES     2'h3

`endif

// ===== hdl/pcg_clock_switch.v
// base clock source switch and divide-by-two
`timescale 1ns/100ps
`include "pcg_clock_gen_defines.vh"

module pcg_clock_switch
(
  input  wire mclk_in,
  input  wire rst_n_in,
  input  wire clk_en_in,
  input  wire run_in,
  input  wire select_in,
  input  wire crystal_clock_in,
  input  wire vco_clock_in,
  output wire base_clock_out,
  output wire switching_out
);

  localparam ST_RUN    = 1'b0;
  localparam ST_SWITCH = 1'b1;

  reg       state_ff;
  reg       sel_ff;
  reg       out_ff;
  reg       xclk_prev_ff;
  reg       vclk_prev_ff;
  reg [1:0] xcnt_ff;
  reg [1:0] vcnt_ff;

  wire xclk_rise;
  wire vclk_rise;
  wire src_rise;

  assign xclk_rise      = crystal_clock_in & ~xclk_prev_ff;
  assign vclk_rise      = vco_clock_in & ~vclk_prev_ff;
  assign src_rise       = sel_ff ? vclk_rise : xclk_rise;
  assign base_clock_out = out_ff;
  assign switching_out  = (state_ff == ST_SWITCH);

  // ----------------------------------------------------------------------------
  // source edge tracking, switch sequencing, halving
  // ----------------------------------------------------------------------------
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_ff     <= ST_RUN;
      sel_ff       <= 1'b0;
      out_ff       <= 1'b0;
      xclk_prev_ff <= 1'b0;
      vclk_prev_ff <= 1'b0;
      xcnt_ff      <= 2'h0;
      vcnt_ff      <= 2'h0;
    end
    else if (clk_en_in)
    begin
      xclk_prev_ff <= crystal_clock_in;
      vclk_prev_ff <= vco_clock_in;
      if (!run_in)
      begin
        // stopped: output low, take the new source at once
        state_ff <= ST_RUN;
        sel_ff   <= select_in;
        out_ff   <= 1'b0;
        xcnt_ff  <= 2'h0;
        vcnt_ff  <= 2'h0;
      end
      else
      begin
        case (state_ff)
          ST_RUN:
          begin
            if (select_in != sel_ff)
            begin
              state_ff <= ST_SWITCH;
              xcnt_ff  <= 2'h0;
              vcnt_ff  <= 2'h0;
            end
            else if (src_rise)
            begin
              out_ff <= ~out_ff;
            end
          end
          ST_SWITCH:
          begin
            // output held while both sources pass the edge count
            if (xclk_rise && xcnt_ff != `PCG_SWITCH_EDGES)
            begin
              xcnt_ff <= xcnt_ff + 2'h1;
            end
            if (vclk_rise && vcnt_ff != `PCG_SWITCH_EDGES)
            begin
              vcnt_ff <= vcnt_ff + 2'h1;
            end
            if (xcnt_ff == `PCG_SWITCH_EDGES && vcnt_ff == `PCG_SWITCH_EDGES)
            begin
              sel_ff   <= select_in;
              state_ff <= ST_RUN;
            end
          end
          default:
          begin
            state_ff <= ST_RUN;
          end
        endcase
      end
    end
  end

endmodule

// ===== hdl/pcg_clock_gen.v
// pll clock generator control: registers, lock flag, interrupt, base clock
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "pcg_clock_gen_defines.vh"

// ----------------------------------------------------------------------------
// Summary of operation
// - multiplier code equals N, code 0 means 1
// - multiplier select resets to six
// - multiplier writes ignored while pll powered on
// - range select writes ignored while pll powered on
// - range zero disables pll, clears base select
// - range zero refuses setting base clock select
// - range select resets to six
// - auto mode: lock change requests irq if enabled
// - auto mode: lock change sets flag always
// - manual mode: no irq, flag reads zero
// - base select allowed without lock indicator
// - generator keeps running in wait mode
// - stop mode: crystal, base, irq outputs low
// - stop clears base select, stays clear after
// - break clear enabled: break clears stick
// - break clear disabled: flag untouched by access
// - tracking indicator marks acquisition complete
// - control register read clears lock change flag
// - base clock halves source, holds while switching
// - lock indicator set when locked, zero manual
// - interlock between power on and base select
// ----------------------------------------------------------------------------

module pcg_clock_gen
(
  input  wire        mclk_in,
  input  wire        rst_n_in,
  input  wire        clk_en_in,
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output wire [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  input  wire        crystal_clock_in,
  input  wire        vco_clock_in,
  input  wire        lock_detect_in,
  input  wire        tracking_in,
  input  wire        stop_mode_in,
  input  wire        break_state_in,
  output wire        crystal_clock_out,
  output wire        base_clock_out,
  output wire        pll_irq_line_out,
  output wire        pll_enable_out,
  output wire [3:0]  multiplier_n_out,
  output wire [3:0]  vco_range_out,
  output wire        base_switching_out
);

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  reg        ack_ff;
  reg [31:0] rdata_ff;
  reg        lock_irq_enable_ff;
  reg        lock_change_flag_ff;
  reg        pll_power_on_ff;
  reg        base_clock_select_ff;
  reg        auto_bw_ff;
  reg        manual_track_ff;
  reg        xld_ff;
  reg [3:0]  bw_test_ff;
  reg [3:0]  feedback_multiplier_sel_ff;
  reg [3:0]  vco_range_sel_ff;
  reg        break_clear_enable_ff;
  reg        lock_prev_ff;
  reg        xclk_out_ff;
  reg [3:0]  mult_n_ff;
  reg        pll_en_ff;

  reg        nxt_lock_irq_enable;
  reg        nxt_lock_change_flag;
  reg        nxt_pll_power_on;
  reg        nxt_base_clock_select;
  reg        nxt_auto_bw;
  reg        nxt_manual_track;
  reg        nxt_xld;
  reg [3:0]  nxt_bw_test;
  reg [3:0]  nxt_feedback_multiplier_sel;
  reg [3:0]  nxt_vco_range_sel;
  reg        nxt_break_clear_enable;
  reg [31:0] nxt_rdata;

  wire       req;
  wire       done;
  wire       wr_done;
  wire       rd_done;
  wire       lane0;
  wire [7:0] wbyte;
  wire       sel_ctl;
  wire       sel_bw;
  wire       sel_prg;
  wire       sel_brk;
  wire       lock_ind;
  wire       lock_toggle;
  wire       range_zero;
  wire       flag_protect;
  wire [7:0] ctl_view;
  wire [7:0] bw_view;
  wire [7:0] prg_view;
  wire [7:0] brk_view;
  wire [3:0] mult_n_dec;

  // ----------------------------------------------------------------------------
  // avalon slave handshake: one wait state per access
  // ----------------------------------------------------------------------------
  assign req                 = avs_read_in | avs_write_in;
  // held off while the clock enable freezes the registers
  assign avs_waitrequest_out = req & (~ack_ff | ~clk_en_in);
  assign done                = req & ack_ff;
  assign wr_done             = done & avs_write_in;
  assign rd_done             = done & avs_read_in;
  assign lane0               = avs_byteenable_in[0];
  assign wbyte               = avs_writedata_in[7:0];
  assign avs_readdata_out    = rdata_ff;

  assign sel_ctl = (avs_address_in == `PCG_OFS_CONTROL);
  assign sel_bw  = (avs_address_in == `PCG_OFS_BANDWIDTH);
  assign sel_prg = (avs_address_in == `PCG_OFS_PROGRAMMING);
  assign sel_brk = (avs_address_in == `PCG_OFS_BREAK_FLAG);

  // ----------------------------------------------------------------------------
  // status terms
  // ----------------------------------------------------------------------------
  assign range_zero   = (vco_range_sel_ff == 4'h0);
  assign lock_ind     = auto_bw_ff & pll_en_ff & lock_detect_in;
  assign lock_toggle  = auto_bw_ff & (lock_ind != lock_prev_ff);
  assign flag_protect = break_state_in & ~break_clear_enable_ff;

  assign ctl_view = {lock_irq_enable_ff & auto_bw_ff,
                     lock_change_flag_ff & auto_bw_ff,
                     pll_power_on_ff,
                     base_clock_select_ff,
                     `PCG_CTL_UNUSED_VAL};
  assign bw_view  = {auto_bw_ff,
                     lock_ind,
                     auto_bw_ff ? tracking_in : manual_track_ff,
                     xld_ff & base_clock_select_ff,
                     4'h0};
  assign prg_view = {feedback_multiplier_sel_ff, vco_range_sel_ff};
  assign brk_view = {break_clear_enable_ff, 7'h00};

  // ----------------------------------------------------------------------------
  // multiplier decode: code zero behaves as one
  // ----------------------------------------------------------------------------
  assign mult_n_dec = (feedback_multiplier_sel_ff == 4'h0) ? 4'h1 : feedback_multiplier_sel_ff;

  // ----------------------------------------------------------------------------
  // read data, captured on the wait-state edge
  // ----------------------------------------------------------------------------
  always @*
  begin
    nxt_rdata = rdata_ff;
    if (avs_read_in && !ack_ff)
    begin
      case (avs_address_in)
        `PCG_OFS_CONTROL:
          nxt_rdata = {24'h00_0000, ctl_view};
        `PCG_OFS_BANDWIDTH:
          nxt_rdata = {24'h00_0000, bw_view};
        `PCG_OFS_PROGRAMMING:
          nxt_rdata = {24'h00_0000, prg_view};
        `PCG_OFS_BREAK_FLAG:
          nxt_rdata = {24'h00_0000, brk_view};
        default:
          nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // next register values
  // ----------------------------------------------------------------------------
  always @*
  begin
    nxt_lock_irq_enable         = lock_irq_enable_ff;
    nxt_lock_change_flag        = lock_change_flag_ff;
    nxt_pll_power_on            = pll_power_on_ff;
    nxt_base_clock_select       = base_clock_select_ff;
    nxt_auto_bw                 = auto_bw_ff;
    nxt_manual_track            = manual_track_ff;
    nxt_xld                     = xld_ff;
    nxt_bw_test                 = bw_test_ff;
    nxt_feedback_multiplier_sel = feedback_multiplier_sel_ff;
    nxt_vco_range_sel           = vco_range_sel_ff;
    nxt_break_clear_enable      = break_clear_enable_ff;

    // control register read clears the flag unless protected
    if (rd_done && sel_ctl && !flag_protect)
    begin
      nxt_lock_change_flag = 1'b0;
    end

    if (wr_done && lane0)
    begin
      if (sel_ctl)
      begin
        if (auto_bw_ff)
        begin
          nxt_lock_irq_enable = wbyte[`PCG_CTL_IRQ_EN_BIT];
        end
        // power off refused while base select is set
        if (wbyte[`PCG_CTL_PWR_ON_BIT] || !base_clock_select_ff)
        begin
          nxt_pll_power_on = wbyte[`PCG_CTL_PWR_ON_BIT];
        end
        // no lock check on base select
        if (!wbyte[`PCG_CTL_BCS_BIT])
        begin
          nxt_base_clock_select = 1'b0;
        end
        else if (pll_power_on_ff && !range_zero)
        begin
          nxt_base_clock_select = 1'b1;
        end
      end
      else if (sel_bw)
      begin
        nxt_auto_bw = wbyte[`PCG_BW_AUTO_BIT];
        if (!auto_bw_ff)
        begin
          nxt_manual_track = wbyte[`PCG_BW_TRACK_BIT];
        end
        nxt_xld     = wbyte[`PCG_BW_XLD_BIT];
        nxt_bw_test = wbyte[3:0];
      end
      else if (sel_prg && !pll_power_on_ff)
      begin
        nxt_feedback_multiplier_sel = wbyte[`PCG_PRG_MUL_MSB:`PCG_PRG_MUL_LSB];
        nxt_vco_range_sel           = wbyte[`PCG_PRG_VRS_MSB:`PCG_PRG_VRS_LSB];
      end
      else if (sel_brk)
      begin
        nxt_break_clear_enable = wbyte[`PCG_BRK_BREAK_CLEAR_ENABLE_BIT];
      end
    end

    // manual mode keeps enable and flag cleared
    // a lock change in the clearing cycle wins over the read
    if (!nxt_auto_bw)
    begin
      nxt_lock_irq_enable  = 1'b0;
      nxt_lock_change_flag = 1'b0;
    end
    else if (lock_toggle)
    begin
      nxt_lock_change_flag = 1'b1;
    end

    // zero range or stop forces crystal source
    if (range_zero || stop_mode_in)
    begin
      nxt_base_clock_select = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ack_ff                     <= 1'b0;
      rdata_ff                   <= 32'h0000_0000;
      lock_irq_enable_ff         <= 1'b0;
      lock_change_flag_ff        <= 1'b0;
      pll_power_on_ff            <= `PCG_PWR_ON_RESET;
      base_clock_select_ff       <= 1'b0;
      auto_bw_ff                 <= 1'b0;
      manual_track_ff            <= 1'b0;
      xld_ff                     <= 1'b0;
      bw_test_ff                 <= 4'h0;
      feedback_multiplier_sel_ff <= `PCG_MUL_RESET;
      vco_range_sel_ff           <= `PCG_VRS_RESET;
      break_clear_enable_ff      <= 1'b0;
      lock_prev_ff               <= 1'b0;
      xclk_out_ff                <= 1'b0;
      mult_n_ff                  <= 4'h0;
      pll_en_ff                  <= 1'b0;
    end
    else if (clk_en_in)
    begin
      ack_ff                     <= req & ~ack_ff;
      rdata_ff                   <= nxt_rdata;
      lock_irq_enable_ff         <= nxt_lock_irq_enable;
      lock_change_flag_ff        <= nxt_lock_change_flag;
      pll_power_on_ff            <= nxt_pll_power_on;
      base_clock_select_ff       <= nxt_base_clock_select;
      auto_bw_ff                 <= nxt_auto_bw;
      manual_track_ff            <= nxt_manual_track;
      xld_ff                     <= nxt_xld;
      bw_test_ff                 <= nxt_bw_test;
      feedback_multiplier_sel_ff <= nxt_feedback_multiplier_sel;
      vco_range_sel_ff           <= nxt_vco_range_sel;
      break_clear_enable_ff      <= nxt_break_clear_enable;
      lock_prev_ff               <= lock_ind;
      // generator only halts in stop, not in wait
      xclk_out_ff                <= crystal_clock_in & ~stop_mode_in;
      mult_n_ff                  <= mult_n_dec;
      pll_en_ff                  <= pll_power_on_ff & ~range_zero & ~stop_mode_in;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign crystal_clock_out = xclk_out_ff;
  assign pll_irq_line_out  = lock_change_flag_ff & lock_irq_enable_ff & auto_bw_ff
                             & ~stop_mode_in;
  assign pll_enable_out    = pll_en_ff;
  assign multiplier_n_out  = mult_n_ff;
  assign vco_range_out     = vco_range_sel_ff;

  // ----------------------------------------------------------------------------
  // base clock selector
  // ----------------------------------------------------------------------------
  pcg_clock_switch u_switch
  (
    .mclk_in          (mclk_in),
    .rst_n_in         (rst_n_in),
    .clk_en_in        (clk_en_in),
    .run_in           (~stop_mode_in),
    .select_in        (base_clock_select_ff),
    .crystal_clock_in (crystal_clock_in),
    .vco_clock_in     (vco_clock_in),
    .base_clock_out   (base_clock_out),
    .switching_out    (base_switching_out)
  );

endmodule

// ===== testbench/pcg_clock_gen_properties.sv
// concurrent checks on the ports of the pll clock generator control
`timescale 1ns/100ps

module pcg_clock_gen_properties
(
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic [3:0] avs_address_in,
  input wire logic       avs_read_in,
  input wire logic       avs_write_in,
  input wire logic       avs_waitrequest_out,
  input wire logic       crystal_clock_in,
  input wire logic       stop_mode_in,
  input wire logic       break_state_in,
  input wire logic       crystal_clock_out,
  input wire logic       base_clock_out,
  input wire logic       pll_irq_line_out,
  input wire logic       pll_enable_out,
  input wire logic [3:0] multiplier_n_out,
  input wire logic [3:0] vco_range_out,
  input wire logic       base_switching_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_stop_low: assert property ($past(stop_mode_in) && stop_mode_in |-> !crystal_clock_out && !base_clock_out)
    else $error("clock outputs not low in stop");
  a_irq_stop: assert property (stop_mode_in |-> !pll_irq_line_out)
    else $error("interrupt line high in stop");
  a_range_zero_off: assert property ($past(vco_range_out) == 4'h0 |-> !pll_enable_out)
    else $error("pll enabled with range zero");
  a_range_locked: assert property (pll_enable_out |=> $stable(vco_range_out))
    else $error("range changed while pll on");
  a_mul_frozen: assert property (pll_enable_out |=> $stable(multiplier_n_out))
    else $error("multiplier changed while pll on");
  a_mul_nonzero: assert property ($past(rst_n_in) |-> multiplier_n_out != 4'h0)
    else $error("multiplier zero");
  a_read_clears: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h0 && !break_state_in
    |=> !pll_irq_line_out)
    else $error("interrupt survives control read");
  a_switch_hold: assert property (base_switching_out && $past(base_switching_out) |-> $stable(base_clock_out))
    else $error("base clock moved while switching");
  a_crystal_copy: assert property ($past(rst_n_in) && !$past(stop_mode_in)
    |-> crystal_clock_out == $past(crystal_clock_in))
    else $error("crystal output not following source");
  a_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
endmodule

bind pcg_clock_gen pcg_clock_gen_properties i_props (.*);

// ===== testbench/pcg_source_model.sv
// model of crystal oscillator, vco and analog lock detector
`timescale 1ns/100ps

module pcg_source_model
(
  input  wire  mclk_in,
  input  wire  rst_n_in,
  input  wire  pll_enable_in,
  input  wire  lock_req_in,
  input  wire  track_req_in,
  output logic xtal_out,
  output logic vco_out,
  output wire  lock_out,
  output wire  track_out
);
  logic [1:0] xdiv_ff;
  logic       vdiv_ff;

  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      xdiv_ff <= 2'h0;
      vdiv_ff <= 1'b0;
      xtal_out <= 1'b0;
      vco_out <= 1'b0;
    end
    else
    begin
      xdiv_ff <= (xdiv_ff == 2'h2) ? 2'h0 : xdiv_ff + 2'h1;
      if (xdiv_ff == 2'h2)
        xtal_out <= !xtal_out;
      vdiv_ff <= !vdiv_ff;
      // vco stands still while the pll is off
      if (!pll_enable_in)
        vco_out <= 1'b0;
      else if (vdiv_ff)
        vco_out <= !vco_out;
    end
  end

  assign lock_out = pll_enable_in & lock_req_in;
  assign track_out = pll_enable_in & track_req_in;
endmodule

// ===== testbench/tb_pll_clock_generator_control.sv
// register-level testbench of the pll clock generator control
`timescale 1ns/100ps

module tb_pll_clock_generator_control;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        clk_en_in = 1'b1;
  logic [3:0]  avs_address_in = 4'h0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0]  avs_byteenable_in = 4'hF;
  wire  [31:0] avs_readdata_out;
  wire         avs_waitrequest_out, crystal_clock_in, vco_clock_in, lock_detect_in, tracking_in;
  wire         crystal_clock_out, base_clock_out, pll_irq_line_out, pll_enable_out, base_switching_out;
  wire  [3:0]  multiplier_n_out, vco_range_out;
  logic        stop_mode_in = 1'b0;
  logic        break_state_in = 1'b0;
  logic        lock_req = 1'b0;
  logic        track_req = 1'b0;
  logic [7:0]  rdata;
  int          num_errors = 0;
  int          checks = 0;

  always #10 mclk_in = ~mclk_in;

  pcg_clock_gen i_dut (.*);

  pcg_source_model i_src (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .pll_enable_in(pll_enable_out),
    .lock_req_in(lock_req), .track_req_in(track_req), .xtal_out(crystal_clock_in), .vco_out(vco_clock_in),
    .lock_out(lock_detect_in), .track_out(tracking_in));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] adr, input logic [7:0] dat);
    int n;
    @(posedge mclk_in);
    avs_address_in <= adr;
    avs_writedata_in <= {24'h0, dat};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    n = 0;
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 100);
    if (avs_waitrequest_out !== 1'b0)
    begin
      num_errors++;
      $display("BAD waitrequest expected 0 seen %b", avs_waitrequest_out);
    end
    rdata = avs_readdata_out[7:0];
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] adr, input logic [7:0] exp, input string what);
    bus(1'b0, adr, 8'h00);
    chk(what, exp, rdata);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask

  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(4'h0, 8'h2F, "control");
    rd(4'h4, 8'h00, "bandwidth");
    rd(4'h8, 8'h66, "programming");
    chk("multiplier", 8'h06, {4'h0, multiplier_n_out});
    chk("range", 8'h06, {4'h0, vco_range_out});
    bus(1'b1, 4'h8, 8'h35);
    rd(4'h8, 8'h66, "programming locked");
    bus(1'b1, 4'h2, 8'hFF);
    rd(4'h2, 8'h00, "unmapped");
    bus(1'b1, 4'h0, 8'h00);
    rd(4'h0, 8'h0F, "control off");
    for (int i = 0; i < 16; i++)
    begin
      bus(1'b1, 4'h8, {i[3:0], 4'h5});
      rd(4'h8, {i[3:0], 4'h5}, "programming");
      chk("multiplier", (i == 0) ? 8'h01 : 8'(i), {4'h0, multiplier_n_out});
    end
    bus(1'b1, 4'h8, 8'h30);
    bus(1'b1, 4'h0, 8'h20);
    bus(1'b1, 4'h0, 8'h30);
    rd(4'h0, 8'h2F, "select with range zero");
    chk("pll enable", 8'h00, {7'h0, pll_enable_out});
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b1, 4'h8, 8'h46);
    bus(1'b1, 4'h0, 8'h10);
    rd(4'h0, 8'h0F, "select with pll off");
    bus(1'b1, 4'h0, 8'h20);
    bus(1'b1, 4'h0, 8'h30);
    rd(4'h0, 8'h3F, "select without lock");
    chk("switching on", 8'h01, {7'h0, base_switching_out});
    settle(40);
    chk("switching", 8'h00, {7'h0, base_switching_out});
    bus(1'b1, 4'h0, 8'h10);
    rd(4'h0, 8'h3F, "power off refused");
    lock_req <= 1'b1;
    bus(1'b1, 4'h0, 8'hB0);
    rd(4'h0, 8'h3F, "manual mode control");
    chk("irq manual", 8'h00, {7'h0, pll_irq_line_out});
    bus(1'b1, 4'h4, 8'h80);
    rd(4'h0, 8'h7F, "flag without enable");
    rd(4'h0, 8'h3F, "flag after read");
    rd(4'h4, 8'hC0, "bandwidth locked");
    track_req <= 1'b1;
    rd(4'h4, 8'hE0, "bandwidth tracking");
    bus(1'b1, 4'h0, 8'hB0);
    lock_req <= 1'b0;
    settle(4);
    chk("irq on lock loss", 8'h01, {7'h0, pll_irq_line_out});
    rd(4'h4, 8'hA0, "lock after irq");
    rd(4'h0, 8'hFF, "control with irq");
    settle(1);
    chk("irq after read", 8'h00, {7'h0, pll_irq_line_out});
    @(posedge mclk_in);
    break_state_in <= 1'b1;
    lock_req <= 1'b1;
    rd(4'h0, 8'hFF, "flag in break");
    rd(4'h0, 8'hFF, "flag kept in break");
    bus(1'b1, 4'hC, 8'h80);
    rd(4'h0, 8'hFF, "flag cleared in break");
    break_state_in <= 1'b0;
    rd(4'h0, 8'hBF, "flag after break");
    stop_mode_in <= 1'b1;
    settle(6);
    chk("stop outputs", 8'h00, {5'h0, crystal_clock_out, base_clock_out, pll_irq_line_out});
    @(posedge mclk_in);
    stop_mode_in <= 1'b0;
    settle(4);
    // control read checks base select stays clear after stop
    bus(1'b0, 4'h0, 8'h00);
    chk("select after stop", 8'h00, rdata & 8'h10);
    stop_test;
  end

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    num_errors++;
    $display("BAD watchdog expected done seen hang");
    stop_test;
  end
endmodule
